// ---- rtl/cac_control.sv ----
// counter_array_control register: run control and event flags of the counter array
// assumes counter, module and watchdog status arrive from logic on mclk
//
// What this block does
// RULE1: counter wrap 0xFFFF to 0x0000 sets overflow flag
// RULE2: enabled overflow flag raises counter array interrupt
// RULE3: five module flags bits 0-4, hardware set
// RULE4: enabled module flag raises shared interrupt
// RULE5: flags stay set until software writes zero
// RULE6: bit 6 runs counter, bit 5 reads zero
// RULE7: watchdog forces counter on, bit reads software value
// RULE8: watchdog on, writing one to bit 4 resets
`timescale 1ns/10ps
`include "cac_defs.svh"

module cac_control (
  input wire logic mclk,
  input wire logic srst,
  input wire cac_pkg::cac_sfr_wr_t sfrWr,
  input wire cac_pkg::cac_bit_wr_t bitWr,
  input wire logic counterTick,
  input wire logic [15:0] counterValue,
  input wire logic [4:0] moduleEvent,
  input wire logic overflowIrqEnable,
  input wire logic [4:0] moduleIrqEnable,
  input wire logic watchdogEnabled,
  output cac_pkg::cac_ctrl_t ctrlRead_q,
  output logic counterRun_q,
  output logic irqRequest_q,
  output logic watchdogReset_q
);

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic byteHit;
  logic bitHit;
  logic [7:0] bitSelect;
  logic [7:0] wrEn;
  logic [7:0] wrVal;
  logic [7:0] ctrlAddr;

  // byte write wins if a bit write lands on the same cycle
  assign ctrlAddr = `CAC_CTRL_ADDR;
  assign byteHit = sfrWr.en && (sfrWr.addr == ctrlAddr);
  // bit addresses D8..DF each reach one bit of the register
  assign bitHit = bitWr.en && (bitWr.addr[7:3] == ctrlAddr[7:3]);
  assign bitSelect = bitHit ? (8'h01 << bitWr.addr[2:0]) : 8'h00;
  assign wrEn = byteHit ? 8'hFF : bitSelect;
  assign wrVal = byteHit ? sfrWr.data : {8{bitWr.val}};

  // ----------------------------------------------------------------
  // hardware events
  // ----------------------------------------------------------------
  logic counterWrap;
  logic [5:0] flagSet;
  logic [5:0] flagWrEn;
  logic [5:0] flagWrVal;
  logic [5:0] flagNext;
  logic [5:0] flag_q;

  // counter steps from its top value back to zero only while running
  assign counterWrap = counterTick && counterRun_q && (counterValue == `CAC_COUNTER_MAX); // [RULE1]
  // index 5 holds the overflow flag, 4..0 the module flags
  assign flagSet = {counterWrap, moduleEvent}; // [RULE1] [RULE3]
  assign flagWrEn = {wrEn[`CAC_OVF_BIT], wrEn[4:0]};
  assign flagWrVal = {wrVal[`CAC_OVF_BIT], wrVal[4:0]};

  // ----------------------------------------------------------------
  // sticky flags, cleared only by a write or by srst
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CAC_NUM_FLAGS; gi++) begin : g_flag
      cac_flag_bit u_flag (
        .mclk(mclk),
        .srst(srst),
        .setEvent(flagSet[gi]),
        .wrEn(flagWrEn[gi]),
        .wrVal(flagWrVal[gi]),
        .flagNext(flagNext[gi]),
        .flag_q(flag_q[gi])
      ); // [RULE5]
    end
  endgenerate

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  logic runCtrl_q;
  logic runCtrl_d;
  logic runNext;

  // software value is kept even under watchdog, so it reads back honestly
  assign runCtrl_d = wrEn[`CAC_RUN_BIT] ? wrVal[`CAC_RUN_BIT] : runCtrl_q; // [RULE6] [RULE7]
  // watchdog holds the counter on whatever software writes
  assign runNext = runCtrl_d | watchdogEnabled; // [RULE7]

  always_ff @(posedge mclk) begin
    if (srst) begin
      runCtrl_q <= 1'b0;
    end else begin
      runCtrl_q <= runCtrl_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  cac_pkg::cac_ctrl_t ctrlNext;
  logic irqNext;
  logic watchdogForce;

  // bit 5 is hardwired low
  assign ctrlNext = '{counterOverflowFlag: flagNext[5], counterRunControl: runCtrl_d,
                      unusedBit: 1'b0, moduleMatchFlag: flagNext[4:0]}; // [RULE6]
  assign irqNext = (flagNext[5] && overflowIrqEnable) || ((flagNext[4:0] & moduleIrqEnable) != 5'h00); // [RULE2] [RULE4]
  // writing one to module 4 flag under watchdog is a forced reset
  assign watchdogForce = watchdogEnabled && wrEn[`CAC_WATCHDOG_FORCE_BIT] && wrVal[`CAC_WATCHDOG_FORCE_BIT]; // [RULE8]

  // read image mirrors the flops so software never sees a stale copy
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrlRead_q <= `CAC_CTRL_RESET;
      counterRun_q <= 1'b0;
      irqRequest_q <= 1'b0;
      watchdogReset_q <= 1'b0;
    end else begin
      ctrlRead_q <= ctrlNext;
      counterRun_q <= runNext;
      irqRequest_q <= irqNext;
      watchdogReset_q <= watchdogForce;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  logic [4:0] keptFlags;
  assign keptFlags = ctrlRead_q.moduleMatchFlag & ~flagWrEn[4:0];

  property p_ovf_set;
    counterTick && counterRun_q && (counterValue == 16'hFFFF) |=> ctrlRead_q.counterOverflowFlag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap"); // [RULE1]

  property p_ovf_irq;
    ctrlRead_q.counterOverflowFlag && !flagWrEn[5] && overflowIrqEnable |=> irqRequest_q;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing"); // [RULE2]

  property p_mod_set;
    moduleEvent != 5'h00 |=> (ctrlRead_q.moduleMatchFlag & $past(moduleEvent)) == $past(moduleEvent);
  endproperty
  a_mod_set: assert property (p_mod_set) else $error("module flag not set on event"); // [RULE3]

  property p_mod_irq;
    ((keptFlags & moduleIrqEnable) != 5'h00) |=> irqRequest_q;
  endproperty
  a_mod_irq: assert property (p_mod_irq) else $error("module interrupt missing"); // [RULE4]

  property p_no_irq;
    !ctrlRead_q.counterOverflowFlag && (ctrlRead_q.moduleMatchFlag == 5'h00) |-> !irqRequest_q;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("spurious interrupt"); // [RULE4]

  property p_sticky;
    keptFlags != 5'h00 |=> (ctrlRead_q.moduleMatchFlag & $past(keptFlags)) == $past(keptFlags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a write"); // [RULE5]

  property p_run_stop;
    wrEn[6] && !wrVal[6] && !watchdogEnabled |=> !counterRun_q && !ctrlRead_q.counterRunControl
      && !ctrlRead_q.unusedBit;
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("counter did not stop"); // [RULE6]

  property p_watchdog_run;
    watchdogEnabled && !runCtrl_q && !wrEn[6] |=> counterRun_q && !ctrlRead_q.counterRunControl;
  endproperty
  a_watchdog_run: assert property (p_watchdog_run) else $error("watchdog run state wrong"); // [RULE7]

  // the pulse lasts one cycle per forcing write
  property p_watchdog_force;
    watchdogForce |=> watchdogReset_q ##1 (watchdogReset_q == $past(watchdogForce));
  endproperty
  a_watchdog_force: assert property (p_watchdog_force) else $error("forced watchdog reset wrong"); // [RULE8]

  property p_watchdog_quiet;
    !watchdogEnabled |=> !watchdogReset_q;
  endproperty
  a_watchdog_quiet: assert property (p_watchdog_quiet) else $error("watchdog reset while disabled"); // [RULE8]

  property p_run_set;
    wrEn[6] && wrVal[6] |=> counterRun_q && ctrlRead_q.counterRunControl;
  endproperty
  a_run_set: assert property (p_run_set) else $error("counter did not start"); // [RULE6]

  property p_bit5_low;
    wrEn[5] && wrVal[5] |=> !ctrlRead_q.unusedBit;
  endproperty
  a_bit5_low: assert property (p_bit5_low) else $error("unused bit took a write"); // [RULE6]

  property p_byte_wins;
    byteHit && bitHit |=> ctrlRead_q.counterRunControl == $past(sfrWr.data[6]);
  endproperty
  a_byte_wins: assert property (p_byte_wins) else $error("bit write beat byte write"); // [RULE6]

  property p_ovf_quiet;
    !counterWrap && !ctrlRead_q.counterOverflowFlag && !(flagWrEn[5] && flagWrVal[5])
      |=> !ctrlRead_q.counterOverflowFlag;
  endproperty
  a_ovf_quiet: assert property (p_ovf_quiet) else $error("overflow flag set without a wrap"); // [RULE1]

  property p_sw_clear;
    flagWrEn[0] && !flagWrVal[0] && !moduleEvent[0] |=> !ctrlRead_q.moduleMatchFlag[0];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear of module 0 flag lost"); // [RULE5]

  c_wrap: cover property (counterWrap ##1 irqRequest_q);
  c_clear: cover property (ctrlRead_q.moduleMatchFlag[0] ##1 !ctrlRead_q.moduleMatchFlag[0]);
  c_force: cover property (watchdogReset_q);
  c_set_clear: cover property (flagSet[0] && flagWrEn[0] && !flagWrVal[0]);
  c_watchdog_hold: cover property (watchdogEnabled && !runCtrl_q && counterRun_q);

endmodule

// ---- rtl/cac_defs.svh ----
// constants for the counter array control register block
// assumes inclusion by bare name from the package and the design files
`ifndef CAC_DEFS_SVH
`define CAC_DEFS_SVH

// ----------------------------------------------------------------
// register placement
// ----------------------------------------------------------------
`define CAC_CTRL_ADDR 8'hD8
`define CAC_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// field positions inside counter_array_control
// ----------------------------------------------------------------
`define CAC_OVF_BIT 3'h7
`define CAC_RUN_BIT 3'h6
`define CAC_UNUSED_BIT 3'h5
`define CAC_WATCHDOG_FORCE_BIT 3'h4
`define CAC_NUM_MODULES 5
`define CAC_NUM_FLAGS 6

// ----------------------------------------------------------------
// counter limits
// ----------------------------------------------------------------
`define CAC_COUNTER_MAX 16'hFFFF

`endif

// ---- rtl/cac_flag_bit.sv ----
// one sticky event flag with software write access
// assumes set and write strobes come from logic on mclk
`timescale 1ns/10ps

module cac_flag_bit (
  input wire logic mclk,
  input wire logic srst,
  input wire logic setEvent,
  input wire logic wrEn,
  input wire logic wrVal,
  output logic flagNext,
  output logic flag_q
);

  // ----------------------------------------------------------------
  // next value: a hardware set beats a clear in the same cycle
  // ----------------------------------------------------------------
  assign flagNext = setEvent | (wrEn ? wrVal : flag_q);

  // sticky storage, only a write or srst can drop it
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flagNext;
    end
  end

endmodule

// ---- rtl/cac_pkg.sv ----
// types shared by the counter array control register block
// assumes cac_defs.svh is on the include path
`include "cac_defs.svh"

package cac_pkg;

  // image of counter_array_control as software sees it
  typedef struct packed {
    logic counterOverflowFlag;
    logic counterRunControl;
    logic unusedBit;
    logic [4:0] moduleMatchFlag;
  } cac_ctrl_t;

  // byte-wide register write port
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } cac_sfr_wr_t;

  // single-bit write from a bit-addressed instruction
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic val;
  } cac_bit_wr_t;

endpackage

// ---- test/cac_testbench.sv ----
// self-checking bench for the counter array control register
// assumes the rtl/ files are compiled first, one mclk domain
`timescale 1ns/10ps
`include "cac_defs.svh"

module testbench;
  logic mclk;
  logic srst;
  cac_pkg::cac_sfr_wr_t sfrWr;
  cac_pkg::cac_bit_wr_t bitWr;
  logic counterTick;
  logic [15:0] counterValue;
  logic [4:0] moduleEvent;
  logic overflowIrqEnable;
  logic [4:0] moduleIrqEnable;
  logic watchdogEnabled;
  cac_pkg::cac_ctrl_t ctrlRead_q;
  logic counterRun_q;
  logic irqRequest_q;
  logic watchdogReset_q;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  cac_control dut (.mclk(mclk), .srst(srst), .sfrWr(sfrWr), .bitWr(bitWr), .counterTick(counterTick),
    .counterValue(counterValue), .moduleEvent(moduleEvent), .overflowIrqEnable(overflowIrqEnable),
    .moduleIrqEnable(moduleIrqEnable), .watchdogEnabled(watchdogEnabled), .ctrlRead_q(ctrlRead_q),
    .counterRun_q(counterRun_q), .irqRequest_q(irqRequest_q), .watchdogReset_q(watchdogReset_q));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // the whole run needs about 80 cycles, so 2000 only trips on a hang
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // inputs move 1 ns after the edge so the edge sees them settled
  task cyc;
    @(posedge mclk);
    #1;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single-bit outputs get their own compare so nothing is padded
  task chkBit(input logic got, input logic exp);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // an idle edge first, so a strobe dropped by the last call is never raised in the same step
  task wrByte(input logic [7:0] a, input logic [7:0] d);
    cyc;
    sfrWr = {1'b1, a, d};
    cyc;
    sfrWr.en = 1'b0;
  endtask

  task wrBit(input logic [2:0] n, input logic v);
    cyc;
    bitWr = {1'b1, `CAC_CTRL_ADDR + {5'h00, n}, v};
    cyc;
    bitWr.en = 1'b0;
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task test_run;
    chk(ctrlRead_q, `CAC_CTRL_RESET);
    chkBit(counterRun_q, 1'b0);
    chkBit(irqRequest_q, 1'b0);
    chkBit(watchdogReset_q, 1'b0);
    wrByte(`CAC_CTRL_ADDR, 8'h40);
    chk(ctrlRead_q, 8'h40);
    chkBit(counterRun_q, 1'b1);
    wrByte(8'hD9, 8'h00);
    chk(ctrlRead_q, 8'h40);
    wrByte(`CAC_CTRL_ADDR, 8'h20);
    chk(ctrlRead_q, 8'h00);
    chkBit(counterRun_q, 1'b0);
    // byte and bit write on one edge: the byte decides
    cyc;
    sfrWr = {1'b1, `CAC_CTRL_ADDR, 8'h40};
    bitWr = {1'b1, `CAC_CTRL_ADDR + 8'h06, 1'b0};
    cyc;
    sfrWr.en = 1'b0;
    bitWr.en = 1'b0;
    chk(ctrlRead_q, 8'h40);
    wrBit(3'h6, 1'b0);
    chk(ctrlRead_q, 8'h00);
    $display("test run done");
  endtask

  task test_overflow;
    overflowIrqEnable = 1'b1;
    // a tick at the top value while stopped is no overflow
    counterTick = 1'b1;
    counterValue = 16'hFFFF;
    cyc;
    counterTick = 1'b0;
    chk(ctrlRead_q, 8'h00);
    chkBit(irqRequest_q, 1'b0);
    wrByte(`CAC_CTRL_ADDR, 8'h40);
    counterTick = 1'b1;
    counterValue = 16'hFFFE;
    cyc;
    chk(ctrlRead_q, 8'h40);
    counterValue = 16'hFFFF;
    cyc;
    counterTick = 1'b0;
    chk(ctrlRead_q, 8'hC0);
    chkBit(irqRequest_q, 1'b1);
    overflowIrqEnable = 1'b0;
    repeat (3) cyc;
    chkBit(irqRequest_q, 1'b0);
    chk(ctrlRead_q, 8'hC0);
    wrBit(3'h7, 1'b0);
    chk(ctrlRead_q, 8'h40);
    $display("test overflow done");
  endtask

  task test_modules;
    moduleIrqEnable = 5'h1F;
    for (int i = 0; i < 5; i++) begin
      moduleEvent = 5'h01 << i;
      cyc;
      moduleEvent = 5'h00;
      chk(ctrlRead_q, 8'h40 | (8'h01 << i));
      chkBit(irqRequest_q, 1'b1);
      repeat (3) cyc;
      chk(ctrlRead_q, 8'h40 | (8'h01 << i));
      wrBit(i[2:0], 1'b0);
      chk(ctrlRead_q, 8'h40);
      chkBit(irqRequest_q, 1'b0);
    end
    // event and clearing write on one edge: the event wins
    cyc;
    moduleEvent = 5'h01;
    bitWr = {1'b1, `CAC_CTRL_ADDR, 1'b0};
    cyc;
    moduleEvent = 5'h00;
    bitWr.en = 1'b0;
    chk(ctrlRead_q, 8'h41);
    wrBit(3'h0, 1'b0);
    chk(ctrlRead_q, 8'h40);
    // a masked module must not reach the shared request
    moduleIrqEnable = 5'h1B;
    moduleEvent = 5'h04;
    cyc;
    moduleEvent = 5'h00;
    cyc;
    chkBit(irqRequest_q, 1'b0);
    chk(ctrlRead_q, 8'h44);
    wrBit(3'h4, 1'b1);
    chkBit(watchdogReset_q, 1'b0);
    chk(ctrlRead_q, 8'h54);
    chkBit(irqRequest_q, 1'b1);
    $display("test modules done");
  endtask

  task test_reset;
    // reset in mid-run with flags, run bit and request all up
    srst = 1'b1;
    cyc;
    chk(ctrlRead_q, `CAC_CTRL_RESET);
    chkBit(counterRun_q, 1'b0);
    chkBit(irqRequest_q, 1'b0);
    srst = 1'b0;
    cyc;
    chk(ctrlRead_q, `CAC_CTRL_RESET);
    chkBit(irqRequest_q, 1'b0);
    $display("test reset done");
  endtask

  task test_watchdog;
    wrByte(`CAC_CTRL_ADDR, 8'h00);
    watchdogEnabled = 1'b1;
    cyc;
    chkBit(counterRun_q, 1'b1);
    chk(ctrlRead_q, 8'h00);
    wrBit(3'h6, 1'b1);
    chk(ctrlRead_q, 8'h40);
    wrBit(3'h6, 1'b0);
    chk(ctrlRead_q, 8'h00);
    chkBit(counterRun_q, 1'b1);
    wrBit(3'h4, 1'b1);
    chkBit(watchdogReset_q, 1'b1);
    cyc;
    chkBit(watchdogReset_q, 1'b0);
    chk(ctrlRead_q, 8'h10);
    watchdogEnabled = 1'b0;
    cyc;
    chkBit(counterRun_q, 1'b0);
    $display("test watchdog done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    sfrWr = '0;
    bitWr = '0;
    counterTick = 1'b0;
    counterValue = 16'h0000;
    moduleEvent = 5'h00;
    overflowIrqEnable = 1'b0;
    moduleIrqEnable = 5'h00;
    watchdogEnabled = 1'b0;
    repeat (5) cyc;
    srst = 1'b0;
    cyc;
    test_run();
    test_overflow();
    test_modules();
    test_reset();
    test_watchdog();
    print_verdict();
  end
endmodule
